// >>> rtl/awps_pkg.sv
// Package: constants and types for the arbitrary waveform playback store
package awps_pkg;
  localparam int CLK_NS = 25;
  localparam int RATE_DEF_NS = 1000;
  localparam int RATE_DEF_CYC = (RATE_DEF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRIG_DEF_NS = 10000000;
  localparam int TRIG_DEF_CYC = TRIG_DEF_NS / CLK_NS;
  localparam int WAVE_PTS = 1000;
  localparam int NSLOTS = 20;
  localparam int SMP_MAX = 2047;
  localparam int SCALE_DIV = 4095;
  localparam int SCALE_FULL = 100;
  localparam int START_MIN = 1;
  localparam int START_MAX = 999;
  localparam int LEN_MIN = 2;
  localparam int LEN_MAX = 1000;
  localparam int EDIT_MIN = 1;
  localparam int STORE_MIN = 1;
  localparam int STORE_MAX = 19;
  localparam int RECALL_MAX = 19;
  localparam int AMPL_MAX = 10000;
  localparam int OFFS_MAX = 5000;
  localparam int RATE_MAX = 65535;
  localparam int PD_MIN_LONG = 16;
  localparam int PD_MIN_SQUARE = 2;
  localparam int START_DEF = 1;
  localparam int LEN_DEF = 500;
  localparam int AMPL_DEF = 5000;
  localparam int OFFS_DEF = 0;
  localparam int EDIT_DEF = 1;
  localparam int PD_SHAPE_LSB = 16;
  // Register word offsets
  localparam logic [3:0] A_EDIT = 4'h0;
  localparam logic [3:0] A_DATA = 4'h1;
  localparam logic [3:0] A_START = 4'h2;
  localparam logic [3:0] A_LEN = 4'h3;
  localparam logic [3:0] A_RATE = 4'h4;
  localparam logic [3:0] A_AMPL = 4'h5;
  localparam logic [3:0] A_OFFS = 4'h6;
  localparam logic [3:0] A_TRIG = 4'h7;
  localparam logic [3:0] A_CTRL = 4'h8;
  localparam logic [3:0] A_STORE = 4'h9;
  localparam logic [3:0] A_RECALL = 4'ha;
  localparam logic [3:0] A_PROT = 4'hb;
  localparam logic [3:0] A_PREDEF = 4'hc;
  localparam logic [3:0] A_SCALE = 4'hd;
  localparam logic [3:0] A_STATUS = 4'he;
  localparam logic [3:0] A_PTR = 4'hf;
  // Error flag positions in the status word
  localparam int E_RANGE = 0;
  localparam int E_CONFLICT = 1;
  localparam int E_TRIG = 2;
  localparam int E_EMPTY = 3;
  localparam int E_SCALE = 4;
  localparam int E_PROT = 5;
  localparam int E_RAM = 6;
  localparam int E_DIV4 = 7;
  localparam int E_DIV2 = 8;
  localparam int ERR_W = 9;
  localparam int BUSY_BIT = 15;
  typedef enum logic [1:0] {AWPS_ST_WR = 2'b00, AWPS_ST_CHK = 2'b01, AWPS_ST_RUN = 2'b11} awps_st_e;
  typedef enum logic [1:0] {AWPS_PD_SINE = 2'h0, AWPS_PD_TRI = 2'h1, AWPS_PD_SQUARE = 2'h2,
                            AWPS_PD_NOISE = 2'h3} awps_pd_e;
  typedef struct packed {
    logic [9:0] start;
    logic [9:0] len;
    logic [15:0] rate;
    logic [13:0] ampl;
    logic signed [15:0] offs;
    logic [31:0] trig;
  } awps_cfg_s;
endpackage : awps_pkg

// >>> rtl/awps_top.sv
// Arbitrary waveform store, settings buffers, error flags and scaled playback
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module awps_top
  import awps_pkg::*;
#(
  parameter int unsigned TRIG_CYC = TRIG_DEF_CYC
)
(
  input wire logic clk, // 40 MHz system clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [3:0] reg_addr, // Register word offset
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  output logic signed [15:0] dac_data, // Scaled sample in mV
  output logic dac_strobe // One-cycle pulse per new sample
);
  localparam awps_cfg_s CFG_DEF = '{start: 10'(START_DEF), len: 10'(LEN_DEF), rate: 16'(RATE_DEF_CYC),
                                    ampl: 14'(AMPL_DEF), offs: 16'(OFFS_DEF), trig: 32'(TRIG_CYC)};

  awps_cfg_s cfg_reg;
  awps_cfg_s slot_mem [NSLOTS];
  logic signed [11:0] mem [WAVE_PTS];
  logic [NSLOTS-1:0] slot_vld_reg;
  logic [10:0] edit_addr_reg;
  logic [9:0] prot_reg;
  logic [7:0] scale_reg;
  logic ctrl_play_reg;
  logic [ERR_W-1:0] err_reg;
  logic [ERR_W-1:0] err_set;
  logic cfg_chg_reg;
  awps_st_e st_reg;
  logic [9:0] st_idx_reg;
  logic [9:0] ptr_reg;
  logic [15:0] cnt_reg;
  logic signed [11:0] smp_reg;
  logic smp_v_reg;

  logic signed [31:0] wds;
  logic busy, addr_ok, prot_hit, samp_ok, data_ok;
  logic start_ok, start_cf, len_ok, len_cf, rate_ok, ampl_ok, offs_ok, trig_ok;
  logic store_ok, recall_rng, recall_hit, cfg_wr, scale_ok;
  logic [4:0] buf_idx;
  logic [9:0] edit_idx;
  logic signed [11:0] edit_smp;
  logic [10:0] edit_mag;
  logic [9:0] pd_len;
  logic [1:0] pd_shape;
  logic [9:0] last_ptr;
  logic tick, restart;
  logic [11:0] st_pat;
  logic [25:0] period_cyc;
  logic signed [26:0] prod;
  logic signed [27:0] rnd;
  logic signed [27:0] quo;
  logic [31:0] rd_mux;

  assign wds = $signed(reg_wdata);
  assign busy = (st_reg != AWPS_ST_RUN);
  assign addr_ok = (edit_addr_reg >= 11'(EDIT_MIN)) && (edit_addr_reg <= 11'(WAVE_PTS));
  assign edit_idx = addr_ok ? 10'(edit_addr_reg - 11'd1) : 10'h000;
  assign edit_smp = addr_ok ? mem[edit_idx] : 12'sh000;
  assign edit_mag = edit_smp[11] ? 11'(-edit_smp) : 11'(edit_smp);
  assign prot_hit = (edit_addr_reg <= {1'b0, prot_reg});
  assign samp_ok = (wds >= -SMP_MAX) && (wds <= SMP_MAX);
  assign data_ok = reg_wr && (reg_addr == A_DATA) && !busy && samp_ok && addr_ok && !prot_hit;
  assign start_ok = (reg_wdata >= 32'(START_MIN)) && (reg_wdata <= 32'(START_MAX));
  assign start_cf = (reg_wdata + 32'(cfg_reg.len)) > 32'(WAVE_PTS + 1);
  assign len_ok = (reg_wdata >= 32'(LEN_MIN)) && (reg_wdata <= 32'(LEN_MAX));
  assign len_cf = (reg_wdata + 32'(cfg_reg.start)) > 32'(WAVE_PTS + 1);
  assign rate_ok = (reg_wdata != 32'h0) && (reg_wdata <= 32'(RATE_MAX));
  assign ampl_ok = (reg_wdata <= 32'(AMPL_MAX));
  assign offs_ok = (wds >= -OFFS_MAX) && (wds <= OFFS_MAX);
  assign trig_ok = (reg_wdata != 32'h0);
  assign buf_idx = reg_wdata[4:0];
  assign store_ok = (reg_wdata >= 32'(STORE_MIN)) && (reg_wdata <= 32'(STORE_MAX));
  assign recall_rng = (reg_wdata <= 32'(RECALL_MAX));
  assign recall_hit = (buf_idx == 5'h00) || slot_vld_reg[buf_idx];
  assign scale_ok = (32'(edit_mag) * 32'(reg_wdata[15:0])) <= 32'(SMP_MAX * SCALE_FULL);
  assign pd_len = reg_wdata[9:0];
  assign pd_shape = reg_wdata[PD_SHAPE_LSB+1:PD_SHAPE_LSB];
  assign period_cyc = 26'(cfg_reg.len) * 26'(cfg_reg.rate);
  assign last_ptr = 10'(cfg_reg.start + cfg_reg.len - 10'd1);
  assign st_pat = {2'b10, st_idx_reg ^ 10'h2aa};

  // Which accepted writes change the live settings
  always_comb
  begin
    cfg_wr = 1'b0;
    if (reg_wr)
    begin
      if (reg_addr == A_START)
        cfg_wr = start_ok && !start_cf;
      else if (reg_addr == A_LEN)
        cfg_wr = len_ok && !len_cf;
      else if (reg_addr == A_RATE)
        cfg_wr = rate_ok;
      else if (reg_addr == A_AMPL)
        cfg_wr = ampl_ok;
      else if (reg_addr == A_OFFS)
        cfg_wr = offs_ok;
      else if (reg_addr == A_TRIG)
        cfg_wr = trig_ok;
      else if (reg_addr == A_RECALL)
        cfg_wr = recall_rng && recall_hit;
    end
  end

  // Error sources; each write except to PROT, CTRL, STATUS and PTR is checked (DATA only when not busy), SCALE against the selected sample
  always_comb
  begin
    err_set = '0;
    if (reg_wr)
    begin
      if (reg_addr == A_EDIT)
        err_set[E_RANGE] = (reg_wdata < 32'(EDIT_MIN)) || (reg_wdata > 32'(WAVE_PTS));
      else if (reg_addr == A_DATA && !busy)
      begin
        err_set[E_RANGE] = !samp_ok || !addr_ok;
        err_set[E_PROT] = samp_ok && addr_ok && prot_hit;
      end
      else if (reg_addr == A_START)
      begin
        err_set[E_RANGE] = !start_ok;
        err_set[E_CONFLICT] = start_ok && start_cf;
      end
      else if (reg_addr == A_LEN)
      begin
        err_set[E_RANGE] = !len_ok;
        err_set[E_CONFLICT] = len_ok && len_cf;
      end
      else if (reg_addr == A_RATE)
        err_set[E_RANGE] = !rate_ok;
      else if (reg_addr == A_AMPL)
        err_set[E_RANGE] = !ampl_ok;
      else if (reg_addr == A_OFFS)
        err_set[E_RANGE] = !offs_ok;
      else if (reg_addr == A_TRIG)
        err_set[E_RANGE] = !trig_ok;
      else if (reg_addr == A_STORE)
        err_set[E_RANGE] = !store_ok;
      else if (reg_addr == A_RECALL)
      begin
        err_set[E_RANGE] = !recall_rng;
        err_set[E_EMPTY] = recall_rng && !recall_hit;
      end
      else if (reg_addr == A_PREDEF)
      begin
        if (pd_shape == AWPS_PD_SQUARE)
        begin
          err_set[E_RANGE] = pd_len < 10'(PD_MIN_SQUARE);
          err_set[E_DIV2] = pd_len[0];
        end
        else
        begin
          err_set[E_RANGE] = pd_len < 10'(PD_MIN_LONG);
          err_set[E_DIV4] = (pd_shape != AWPS_PD_NOISE) && (pd_len[1:0] != 2'b00);
        end
      end
      else if (reg_addr == A_SCALE)
        err_set[E_SCALE] = !scale_ok;
    end
    // Trigger rate checked a cycle after any settings change, against the settled values; RAM pattern checked during the test pass
    err_set[E_TRIG] = cfg_chg_reg && (cfg_reg.trig < 32'(period_cyc));
    err_set[E_RAM] = (st_reg == AWPS_ST_CHK) && (mem[st_idx_reg] != st_pat);
  end

  // Sticky flags, cleared by writing ones; a new event in the clear cycle survives
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      err_reg <= '0;
    else if (reg_wr && reg_addr == A_STATUS)
      err_reg <= (err_reg & ~reg_wdata[ERR_W-1:0]) | err_set;
    else
      err_reg <= err_reg | err_set;
  end

  // Live settings
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfg_reg <= CFG_DEF;
    else if (cfg_wr)
    begin
      if (reg_addr == A_RECALL)
        cfg_reg <= (buf_idx == 5'h00) ? CFG_DEF : slot_mem[buf_idx];
      else if (reg_addr == A_START)
        cfg_reg.start <= reg_wdata[9:0];
      else if (reg_addr == A_LEN)
        cfg_reg.len <= reg_wdata[9:0];
      else if (reg_addr == A_RATE)
        cfg_reg.rate <= reg_wdata[15:0];
      else if (reg_addr == A_AMPL)
        cfg_reg.ampl <= reg_wdata[13:0];
      else if (reg_addr == A_OFFS)
        cfg_reg.offs <= reg_wdata[15:0];
      else
        cfg_reg.trig <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfg_chg_reg <= 1'b0;
    else
      cfg_chg_reg <= cfg_wr;
  end

  // Settings buffers; slot 0 is never written, and recalling it loads CFG_DEF
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      slot_vld_reg <= '0;
    else if (reg_wr && reg_addr == A_STORE && store_ok)
      slot_vld_reg[buf_idx] <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reg_wr && reg_addr == A_STORE && store_ok)
      slot_mem[buf_idx] <= cfg_reg;
  end

  // Edit address, protection bound, scale, control
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      edit_addr_reg <= 11'(EDIT_DEF);
      prot_reg <= '0;
      scale_reg <= 8'(SCALE_FULL);
      ctrl_play_reg <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == A_EDIT && !err_set[E_RANGE])
        edit_addr_reg <= reg_wdata[10:0];
      else if (data_ok)
        edit_addr_reg <= edit_addr_reg + 11'd1;
      if (reg_wr && reg_addr == A_PROT)
        prot_reg <= reg_wdata[9:0];
      if (reg_wr && reg_addr == A_SCALE && scale_ok)
        scale_reg <= reg_wdata[7:0];
      if (reg_wr && reg_addr == A_CTRL)
        ctrl_play_reg <= reg_wdata[0];
    end
  end

  // Power-on test writes a pattern, then checks it and clears each word
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= AWPS_ST_WR;
      st_idx_reg <= '0;
    end
    else
    begin
      case (st_reg)
        AWPS_ST_WR:
        begin
          st_idx_reg <= (st_idx_reg == 10'(WAVE_PTS - 1)) ? 10'h000 : st_idx_reg + 10'd1;
          if (st_idx_reg == 10'(WAVE_PTS - 1))
            st_reg <= AWPS_ST_CHK;
        end
        AWPS_ST_CHK:
        begin
          st_idx_reg <= st_idx_reg + 10'd1;
          if (st_idx_reg == 10'(WAVE_PTS - 1))
            st_reg <= AWPS_ST_RUN;
        end
        default:
          st_reg <= AWPS_ST_RUN;
      endcase
    end
  end

  // Waveform memory: no reset, the test pass leaves it zeroed
  always_ff @(posedge clk)
  begin
    if (st_reg == AWPS_ST_WR)
      mem[st_idx_reg] <= st_pat;
    else if (st_reg == AWPS_ST_CHK)
      mem[st_idx_reg] <= 12'sh000;
    else if (data_ok)
      mem[edit_idx] <= reg_wdata[11:0];
  end

  // Playback; any settings change restarts from the start address
  assign restart = !ctrl_play_reg || busy || cfg_chg_reg;
  assign tick = (cnt_reg == cfg_reg.rate - 16'd1);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ptr_reg <= 10'(START_DEF);
      cnt_reg <= '0;
      smp_reg <= '0;
      smp_v_reg <= 1'b0;
    end
    else if (restart)
    begin
      ptr_reg <= cfg_reg.start;
      cnt_reg <= '0;
      smp_v_reg <= 1'b0;
    end
    else
    begin
      smp_v_reg <= tick;
      cnt_reg <= tick ? 16'h0000 : cnt_reg + 16'd1;
      if (tick)
      begin
        smp_reg <= mem[10'(ptr_reg - 10'd1)];
        ptr_reg <= (ptr_reg == last_ptr) ? cfg_reg.start : ptr_reg + 10'd1;
      end
    end
  end

  // Round to nearest so a zero sample lands exactly on the offset
  assign prod = 27'($signed({1'b0, cfg_reg.ampl})) * 27'(smp_reg);
  assign rnd = (prod < 0) ? 28'(prod) - 28'(SCALE_DIV / 2) : 28'(prod) + 28'(SCALE_DIV / 2);
  assign quo = rnd / 28'(SCALE_DIV);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dac_data <= 16'(OFFS_DEF);
      dac_strobe <= 1'b0;
    end
    else
    begin
      dac_strobe <= smp_v_reg;
      if (smp_v_reg)
        dac_data <= 16'(quo) + cfg_reg.offs;
    end
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (reg_addr == A_EDIT)
      rd_mux = 32'(edit_addr_reg);
    else if (reg_addr == A_DATA)
      rd_mux = 32'(edit_smp);
    else if (reg_addr == A_START)
      rd_mux = 32'(cfg_reg.start);
    else if (reg_addr == A_LEN)
      rd_mux = 32'(cfg_reg.len);
    else if (reg_addr == A_RATE)
      rd_mux = 32'(cfg_reg.rate);
    else if (reg_addr == A_AMPL)
      rd_mux = 32'(cfg_reg.ampl);
    else if (reg_addr == A_OFFS)
      rd_mux = 32'(cfg_reg.offs);
    else if (reg_addr == A_TRIG)
      rd_mux = cfg_reg.trig;
    else if (reg_addr == A_CTRL)
      rd_mux = 32'(ctrl_play_reg);
    else if (reg_addr == A_PROT)
      rd_mux = 32'(prot_reg);
    else if (reg_addr == A_SCALE)
      rd_mux = 32'(scale_reg);
    else if (reg_addr == A_STATUS)
      rd_mux = 32'(err_reg) | (32'(busy) << BUSY_BIT);
    else if (reg_addr == A_PTR)
      rd_mux = 32'(ptr_reg);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  // Helper: cycles between output strobes since the last restart
  logic [15:0] gap_reg;
  logic seen_reg, rst_d_reg;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gap_reg <= '0;
      seen_reg <= 1'b0;
      rst_d_reg <= 1'b1;
    end
    else
    begin
      rst_d_reg <= restart;
      gap_reg <= dac_strobe ? 16'h0000 : gap_reg + 16'd1;
      if (restart || rst_d_reg)
        seen_reg <= 1'b0;
      else if (dac_strobe)
        seen_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_incr;
    data_ok |=> edit_addr_reg == $past(edit_addr_reg) + 11'd1;
  endproperty
  a_incr: assert property (p_incr) else $error("edit address did not advance");
  property p_samp;
    reg_wr && reg_addr == A_DATA && !busy && !samp_ok |=> err_reg[E_RANGE] && $stable(edit_addr_reg);
  endproperty
  a_samp: assert property (p_samp) else $error("bad sample accepted");
  property p_gap;
    dac_strobe && seen_reg && !restart |-> gap_reg == cfg_reg.rate - 16'd1;
  endproperty
  a_gap: assert property (p_gap) else $error("sample spacing differs from rate");
  property p_wrap;
    tick && !restart && ptr_reg == last_ptr |=> ptr_reg == $past(cfg_reg.start);
  endproperty
  a_wrap: assert property (p_wrap) else $error("playback did not wrap to start");
  property p_zero;
    smp_v_reg && smp_reg == 12'sh000 |=> dac_data == $past(cfg_reg.offs);
  endproperty
  a_zero: assert property (p_zero) else $error("zero sample not at offset");
  property p_start;
    reg_wr && reg_addr == A_START && !start_ok |=> err_reg[E_RANGE] ##0 $stable(cfg_reg.start);
  endproperty
  a_start: assert property (p_start) else $error("bad start accepted");
  property p_len;
    reg_wr && reg_addr == A_LEN && !len_ok |=> err_reg[E_RANGE] && $stable(cfg_reg.len);
  endproperty
  a_len: assert property (p_len) else $error("bad length accepted");
  property p_store0;
    reg_wr && reg_addr == A_STORE && buf_idx == 5'h00 |=> err_reg[E_RANGE] && !slot_vld_reg[0];
  endproperty
  a_store0: assert property (p_store0) else $error("store to buffer zero allowed");
  property p_recall0;
    reg_wr && reg_addr == A_RECALL && reg_wdata == 32'h0 |=> cfg_reg == CFG_DEF;
  endproperty
  a_recall0: assert property (p_recall0) else $error("buffer zero not defaults");
  property p_empty;
    reg_wr && reg_addr == A_RECALL && recall_rng && !recall_hit |=> err_reg[E_EMPTY] && $stable(cfg_reg);
  endproperty
  a_empty: assert property (p_empty) else $error("empty recall changed settings");
  property p_prot;
    reg_wr && reg_addr == A_DATA && !busy && samp_ok && addr_ok && prot_hit |=> err_reg[E_PROT] ##0
      mem[$past(edit_idx)] == $past(edit_smp);
  endproperty
  a_prot: assert property (p_prot) else $error("protected write not blocked");

  c_play: cover property (dac_strobe && seen_reg);
  c_wrap: cover property (tick && !restart && ptr_reg == last_ptr);
  c_recall: cover property (reg_wr && reg_addr == A_RECALL && buf_idx != 5'h00 && recall_hit);
  c_test_done: cover property (st_reg == AWPS_ST_CHK ##1 st_reg == AWPS_ST_RUN);
endmodule : awps_top

// >>> test/awps_dac_model.sv
// Capture model of the output converter fed by the playback path
`timescale 1ns/1ps
module awps_dac_model
(
  input wire logic clk, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic signed [15:0] dac_data, // Converter input word
  input wire logic dac_strobe // Load pulse
);
  logic signed [15:0] smp_q [$];
  int gap_q [$];
  int cnt;
  // Latches only on the strobe, so a word that changes between strobes is never seen
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt = 0;
    else if (dac_strobe)
    begin
      smp_q.push_back(dac_data);
      gap_q.push_back(cnt);
      cnt = 1;
    end
    else
      cnt = cnt + 1;
  end
endmodule : awps_dac_model

// >>> test/awps_top_tb.sv
// Register-level testbench for the waveform playback store
`timescale 1ns/1ps
module awps_top_tb
  import awps_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic signed [15:0] dac_data;
  logic dac_strobe;
  int err_total = 0;
  int comparisons = 0;
  localparam int OFFS_TB = 100;
  int mem_exp [1:3] = '{2047, 0, -2047};
  logic [31:0] d;
  logic busy;
  int i;

  always #12.5 clk = ~clk;

  // Short trigger reset value keeps the trigger-rate path reachable
  awps_top #(.TRIG_CYC(64)) u_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dac_data(dac_data), .dac_strobe(dac_strobe));
  awps_dac_model u_dac (.clk(clk), .arst_n(arst_n), .dac_data(dac_data), .dac_strobe(dac_strobe));

  task automatic stop_test();
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v & m, e);
  endtask : rchk

  // Write, expect exactly the given error flags, then clear them
  task automatic refuse(input logic [3:0] a, input logic [31:0] v, input logic [31:0] e);
    wr(a, v);
    rchk(A_STATUS, 32'h1ff, e);
    wr(A_STATUS, 32'h1ff);
  endtask : refuse

  function automatic int exp_out(input int v);
    int p;
    // Playback runs with the default amplitude restored by recalling buffer zero
    p = AMPL_DEF * v;
    return ((p >= 0) ? (p + SCALE_DIV / 2) / SCALE_DIV : -((SCALE_DIV / 2 - p) / SCALE_DIV)) + OFFS_TB;
  endfunction : exp_out

  task automatic play_chk(input int s, input int l);
    int k;
    repeat (4) @(posedge clk);
    #1;
    u_dac.smp_q.delete();
    u_dac.gap_q.delete();
    repeat (8 * 6 + 4) @(posedge clk);
    chk(32'(u_dac.smp_q.size() >= 6), 32'h1);
    for (k = 0; k < 6 && k < u_dac.smp_q.size(); k++)
    begin
      chk(32'(u_dac.smp_q[k]), 32'(exp_out(mem_exp[s + k % l])));
      if (k > 0)
        chk(32'(u_dac.gap_q[k]), 32'h8);
    end
  endtask : play_chk

  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    busy = 1'b1;
    for (i = 0; i < 1500 && busy === 1'b1; i++)
    begin
      rd(A_STATUS, d);
      busy = d[BUSY_BIT];
    end
    rchk(A_STATUS, 32'h8040, 32'h0);
    wr(A_STATUS, 32'h1ff);
    wr(A_TRIG, 32'h000f4240);
    rchk(A_START, 32'h3ff, 32'h1);
    rchk(A_LEN, 32'h3ff, 32'h1f4);
    rchk(A_AMPL, 32'h3fff, 32'h1388);
    rchk(A_EDIT, 32'h3ff, 32'h1);
    for (i = 1; i <= 3; i++)
      wr(A_DATA, 32'(mem_exp[i]));
    rchk(A_EDIT, 32'h3ff, 32'h4);
    wr(A_EDIT, 32'h1);
    rchk(A_DATA, 32'hfff, 32'h7ff);
    wr(A_EDIT, 32'h4);
    refuse(A_DATA, 32'h800, 32'h1);
    refuse(A_DATA, 32'hfffff800, 32'h1);
    rchk(A_EDIT, 32'h3ff, 32'h4);
    refuse(A_EDIT, 32'd1001, 32'h1);
    refuse(A_EDIT, 32'd0, 32'h1);
    rchk(A_EDIT, 32'h3ff, 32'h4);
    refuse(A_START, 32'd0, 32'h1);
    refuse(A_START, 32'd1000, 32'h1);
    refuse(A_LEN, 32'd1, 32'h1);
    refuse(A_LEN, 32'd1001, 32'h1);
    refuse(A_RATE, 32'd0, 32'h1);
    refuse(A_AMPL, 32'd10001, 32'h1);
    refuse(A_OFFS, 32'hffffec77, 32'h1);
    refuse(A_START, 32'd999, 32'h2);
    rchk(A_START, 32'h3ff, 32'h1);
    refuse(A_PREDEF, 32'h00012, 32'h80);
    refuse(A_PREDEF, 32'h10012, 32'h80);
    refuse(A_PREDEF, 32'h20003, 32'h100);
    refuse(A_PREDEF, 32'h3000f, 32'h1);
    wr(A_PROT, 32'h2);
    wr(A_EDIT, 32'h1);
    refuse(A_DATA, 32'h5, 32'h20);
    wr(A_EDIT, 32'h1);
    rchk(A_DATA, 32'hfff, 32'h7ff);
    wr(A_PROT, 32'h0);
    refuse(A_SCALE, 32'd101, 32'h10);
    refuse(A_SCALE, 32'd100, 32'h0);
    refuse(A_STORE, 32'd0, 32'h1);
    refuse(A_STORE, 32'd20, 32'h1);
    refuse(A_RECALL, 32'd20, 32'h1);
    refuse(A_RECALL, 32'd5, 32'h8);
    rchk(A_START, 32'h3ff, 32'h1);
    wr(A_LEN, 32'd3);
    refuse(A_STORE, 32'd3, 32'h0);
    wr(A_START, 32'd2);
    refuse(A_STORE, 32'd3, 32'h0);
    wr(A_START, 32'd5);
    refuse(A_RECALL, 32'd3, 32'h0);
    rchk(A_START, 32'h3ff, 32'h2);
    rchk(A_LEN, 32'h3ff, 32'h3);
    wr(A_RECALL, 32'd0);
    rchk(A_START, 32'h3ff, 32'h1);
    rchk(A_LEN, 32'h3ff, 32'h1f4);
    wr(A_LEN, 32'd3);
    wr(A_RATE, 32'd8);
    wr(A_STATUS, 32'h1ff);
    refuse(A_TRIG, 32'd10, 32'h4);
    wr(A_TRIG, 32'h000f4240);
    wr(A_STATUS, 32'h1ff);
    wr(A_OFFS, 32'(OFFS_TB));
    wr(A_CTRL, 32'h1);
    play_chk(1, 3);
    wr(A_START, 32'd2);
    wr(A_LEN, 32'd2);
    play_chk(2, 2);
    stop_test();
  end

  initial
  begin
    repeat (10000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule : awps_top_tb
